//--- ocsd_chan_div.sv
/*
  One output channel: divide-by-N+1 counter with half-period initial
  phase, static sync hold, sync mask, polarity and drive-level control.
  Assumes half_tick marks one half period of the prescaler output clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ocsd_defs.svh"
module ocsd_chan_div
  import ocsd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control
  input wire logic half_tick,
  input wire logic sync_pulse,
  input wire ocsd_chan_cfg_t cfg,
  // Channel outputs
  output logic clk_out,
  output logic [1:0] drive,
  output logic oe_n,
  output logic in_static
);
  logic static_q;
  logic pulse_d;
  logic level;
  logic [9:0] cnt;
  logic [5:0] phase_left;
  logic hold;
  logic power_down;

  // Mask acts at once on the hold, not through the sync state
  assign hold = static_q & ~cfg.mask;
  assign power_down = (cfg.mode == `OCSD_MODE_POWER_DOWN);

  // Static sync state: entered on unmasked sync, left after pulse ends
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      static_q <= 1'b1;
      pulse_d <= 1'b0;
    end else begin
      pulse_d <= sync_pulse & ~cfg.mask;
      if (sync_pulse && !cfg.mask) begin
        static_q <= 1'b1;
      end else if (pulse_d) begin
        static_q <= 1'b0;
      end
    end
  end

  // Counter: phase delay first, then toggle every div+1 half periods
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt <= 10'h000;
      level <= 1'b0;
      phase_left <= 6'h00;
    end else if (hold) begin
      cnt <= 10'h000;
      level <= 1'b0;
      phase_left <= cfg.phase;
    end else if (half_tick) begin
      if (phase_left != 6'h00) begin
        phase_left <= phase_left - 6'h01;
      end else if (cnt == cfg.div) begin
        cnt <= 10'h000;
        level <= ~level;
      end else begin
        cnt <= cnt + 10'h001;
      end
    end
  end

  // Output stage; power-down tristates, mask never enables drivers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      clk_out <= 1'b0;
      drive <= `OCSD_RESET_MODE;
      oe_n <= 1'b0;
      in_static <= 1'b1;
    end else begin
      clk_out <= power_down ? 1'b0 : (level ^ cfg.invert);
      drive <= cfg.mode;
      oe_n <= power_down;
      in_static <= hold;
    end
  end

  chk_hold_static: assert property (@(posedge core_clk) disable iff (reset)
    hold |=> (level == 1'b0) && (cnt == 10'h000))
    else $error("divider not static while held");

  chk_mask_ignores_sync: assert property (@(posedge core_clk) disable iff (reset)
    (cfg.mask && sync_pulse && !pulse_d) |=> $stable(static_q))
    else $error("masked channel reacted to sync");

  chk_divide_toggle: assert property (@(posedge core_clk) disable iff (reset)
    (!hold && half_tick && phase_left == 6'h00 && cnt == cfg.div) |=> level != $past(level))
    else $error("divider missed its toggle");

  chk_phase_delay: assert property (@(posedge core_clk) disable iff (reset)
    (!hold && half_tick && phase_left != 6'h00) |=> $stable(level) && cnt == 10'h000)
    else $error("divider moved during phase delay");

  chk_power_down: assert property (@(posedge core_clk) disable iff (reset)
    power_down |=> oe_n && !clk_out)
    else $error("powered-down channel still drives");

  chk_polarity: assert property (@(posedge core_clk) disable iff (reset)
    (!power_down && $stable(cfg.invert)) |=> clk_out == ($past(level) ^ $past(cfg.invert)))
    else $error("channel polarity wrong");
endmodule : ocsd_chan_div
`default_nettype wire

//--- ocsd_defs.svh
/*
  Register offsets, field positions, reset values and codes for the
  output channel sync and divider block.
  Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef OCSD_DEFS_SVH
`define OCSD_DEFS_SVH

// Register indices; the bus byte address is four times the index
`define OCSD_IDX_PRESCALER_CTRL 12'h433
`define OCSD_IDX_SYNC_SETTINGS 12'h435
`define OCSD_IDX_SYNC_MASK 12'h436
`define OCSD_IDX_CHA_MODE 12'h437
`define OCSD_IDX_CHA_DIV_LOW 12'h438
`define OCSD_IDX_CHA_DIV_HIGH 12'h439
`define OCSD_IDX_CHA_PHASE 12'h43A
`define OCSD_IDX_STATUS 12'h43F

// Field positions
`define OCSD_BIT_PRESCALER_RESET 1
`define OCSD_BIT_SYNC_SOURCE 2
`define OCSD_BIT_OVERRIDE 2
`define OCSD_BIT_MASK_B 1
`define OCSD_BIT_MASK_A 0
`define OCSD_BIT_INVERT 0

// Codes and reset values
`define OCSD_MODE_POWER_DOWN 2'h3
`define OCSD_RESET_AUTO 2'h0
`define OCSD_RESET_MODE 2'h0
`define OCSD_RESET_DIV 10'h000
`define OCSD_RESET_PHASE 6'h00

`endif

//--- ocsd_pkg.sv
/*
  Types shared by the output channel sync and divider block.
  Assumes ocsd_defs.svh is on the include path.
*/
package ocsd_pkg;
  // Per-channel configuration as software sets it
  typedef struct packed {
    logic [1:0] mode;
    logic invert;
    logic [9:0] div;
    logic [5:0] phase;
    logic mask;
  } ocsd_chan_cfg_t;

  // Automatic sync trigger selection
  typedef enum logic [1:0] {
    OCSD_AUTO_OFF = 2'h0,
    OCSD_AUTO_FREQ = 2'h1,
    OCSD_AUTO_PHASE = 2'h2,
    OCSD_AUTO_RSVD = 2'h3
  } ocsd_auto_t;

  // Sync issue sequencer
  typedef enum logic [1:0] {
    OCSD_IDLE,
    OCSD_WAIT_REF,
    OCSD_PULSE
  } ocsd_sync_state_t;
endpackage : ocsd_pkg

//--- ocsd_top.sv
/*
  Output channel sync and divider control: register slave, automatic
  sync trigger, analog-loop gating, reference alignment, two channels.
  Assumes lock, calibration, reference-edge and prescaler-tick inputs are
  synchronous to core_clk and an Avalon-MM master with waitrequest.
*/
// The Avalon-MM register port was chosen for this implementation.
// Overview of operation
// - Two-bit auto sync: off, freq, phase, reserved
// - Unmasked: sync armed after analog calibration and lock
// - Override set: ignore analog lock, auto sync rules
// - Channel B mask releases divider, ignores sync
// - Channel A mask releases divider, ignores sync
// - Mode selects 14/21/28 mA or power down
// - Invert bit flips channel clock polarity
// - Divide ratio is ten-bit value plus one
// - Divider low byte, high two bits next register
// - Six-bit initial phase in half periods
// - Reset clears sync, masks, mode, divider, phase
// - Source bit: direct or next reference edge
// - Dividers run from prescaler; reset bit holds it
`timescale 1ns/100ps
`default_nettype none
`include "ocsd_defs.svh"
module ocsd_top
  import ocsd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Avalon-MM slave, byte addressed
  input wire logic [13:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Loop status
  input wire logic digital_loop_freq_lock,
  input wire logic digital_loop_phase_lock,
  input wire logic analog_loop_calibrated,
  input wire logic analog_loop_locked,
  input wire logic active_ref_edge,
  // Prescaler
  input wire logic prescaler_tick,
  output logic output_prescaler_reset,
  // Channel A
  output logic channel_a_output,
  output logic [1:0] channel_a_drive,
  output logic channel_a_oe_n,
  // Channel B
  output logic channel_b_output,
  output logic [1:0] channel_b_drive,
  output logic channel_b_oe_n,
  // Sync indication
  output logic sync_active
);
  // Software state
  ocsd_auto_t auto_mode;
  logic sync_source_ref;
  logic analog_lock_sync_override;
  logic channel_a_sync_mask;
  logic channel_b_sync_mask;
  logic prescaler_reset;
  ocsd_chan_cfg_t cfg_a;
  ocsd_chan_cfg_t cfg_b;
  // Sync path
  ocsd_sync_state_t state;
  logic armed;
  logic cond_prev;
  logic sync_cond;
  logic trigger;
  logic half_tick;
  logic static_a;
  logic static_b;
  // Bus decode
  logic [11:0] idx;
  logic access_go;
  logic wr_go;
  logic [7:0] next_rdata;

  // Register index from a byte address
  function automatic logic [11:0] ocsd_index(input logic [13:0] addr);
    ocsd_index = addr[13:2];
  endfunction : ocsd_index

  assign idx = ocsd_index(address);
  assign access_go = (read | write) & waitrequest;
  assign wr_go = write & ~waitrequest;

  // One wait state, then a single accept cycle per request
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~access_go;
    end
  end

  // Register writes; unmapped indices are ignored
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      auto_mode <= OCSD_AUTO_OFF;
      sync_source_ref <= 1'b0;
      analog_lock_sync_override <= 1'b0;
      cfg_a.mask <= 1'b0;
      channel_b_sync_mask <= 1'b0;
      prescaler_reset <= 1'b0;
      cfg_a.mode <= `OCSD_RESET_MODE;
      cfg_a.invert <= 1'b0;
      cfg_a.div <= `OCSD_RESET_DIV;
      cfg_a.phase <= `OCSD_RESET_PHASE;
    end else if (wr_go) begin
      case (idx)
        `OCSD_IDX_PRESCALER_CTRL: begin
          prescaler_reset <= writedata[`OCSD_BIT_PRESCALER_RESET];
        end
        `OCSD_IDX_SYNC_SETTINGS: begin
          auto_mode <= ocsd_auto_t'(writedata[1:0]);
          sync_source_ref <= writedata[`OCSD_BIT_SYNC_SOURCE];
        end
        `OCSD_IDX_SYNC_MASK: begin
          analog_lock_sync_override <= writedata[`OCSD_BIT_OVERRIDE];
          channel_b_sync_mask <= writedata[`OCSD_BIT_MASK_B];
          cfg_a.mask <= writedata[`OCSD_BIT_MASK_A];
        end
        `OCSD_IDX_CHA_MODE: begin
          cfg_a.mode <= writedata[2:1];
          cfg_a.invert <= writedata[`OCSD_BIT_INVERT];
        end
        `OCSD_IDX_CHA_DIV_LOW: begin
          cfg_a.div[7:0] <= writedata[7:0];
        end
        `OCSD_IDX_CHA_DIV_HIGH: begin
          cfg_a.div[9:8] <= writedata[1:0];
        end
        `OCSD_IDX_CHA_PHASE: begin
          cfg_a.phase <= writedata[5:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; reserved bits and unmapped indices read zero
  always_comb begin
    next_rdata = 8'h00;
    case (idx)
      `OCSD_IDX_PRESCALER_CTRL: next_rdata = {6'h00, prescaler_reset, 1'b0};
      `OCSD_IDX_SYNC_SETTINGS: next_rdata = {5'h00, sync_source_ref, auto_mode};
      `OCSD_IDX_SYNC_MASK: begin
        next_rdata = {5'h00, analog_lock_sync_override, channel_b_sync_mask, channel_a_sync_mask};
      end
      `OCSD_IDX_CHA_MODE: next_rdata = {5'h00, cfg_a.mode, cfg_a.invert};
      `OCSD_IDX_CHA_DIV_LOW: next_rdata = cfg_a.div[7:0];
      `OCSD_IDX_CHA_DIV_HIGH: next_rdata = {6'h00, cfg_a.div[9:8]};
      `OCSD_IDX_CHA_PHASE: next_rdata = {2'h0, cfg_a.phase};
      `OCSD_IDX_STATUS: next_rdata = {4'h0, static_b, static_a, (state != OCSD_IDLE), armed};
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data ready at the accept edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      readdata <= 32'h00000000;
    end else if (access_go && read) begin
      readdata <= {24'h000000, next_rdata};
    end
  end

  // Channel B keeps its default setup; only its mask is programmable
  always_comb begin
    cfg_b.mode = `OCSD_RESET_MODE;
    cfg_b.invert = 1'b0;
    cfg_b.div = `OCSD_RESET_DIV;
    cfg_b.phase = `OCSD_RESET_PHASE;
    cfg_b.mask = channel_b_sync_mask;
  end

  // Channel A mask lives in its config word; one process owns cfg_a
  assign channel_a_sync_mask = cfg_a.mask;

  // Arming follows analog loop state unless the override is set
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      armed <= 1'b0;
    end else begin
      armed <= analog_lock_sync_override |
        (analog_loop_calibrated & analog_loop_locked);
    end
  end

  // Lock condition picked by the automatic sync field
  always_comb begin
    case (auto_mode)
      OCSD_AUTO_FREQ: sync_cond = digital_loop_freq_lock;
      OCSD_AUTO_PHASE: sync_cond = digital_loop_phase_lock;
      default: sync_cond = 1'b0;
    endcase
  end

  // A rising armed condition is one trigger; a lock held at arming counts
  assign trigger = armed & sync_cond & ~cond_prev;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cond_prev <= 1'b0;
    end else begin
      cond_prev <= armed & sync_cond;
    end
  end

  // Sync sequencer: direct fires at once, reference mode waits an edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= OCSD_IDLE;
    end else begin
      case (state)
        OCSD_IDLE: begin
          if (trigger) begin
            state <= sync_source_ref ? OCSD_WAIT_REF : OCSD_PULSE;
          end
        end
        OCSD_WAIT_REF: begin
          if (!armed) begin
            state <= OCSD_IDLE; // Loss of arming drops a waiting sync
          end else if (active_ref_edge) begin
            state <= OCSD_PULSE;
          end
        end
        OCSD_PULSE: state <= OCSD_IDLE;
        default: state <= OCSD_IDLE;
      endcase
    end
  end

  // Prescaler held while its reset bit is set; dividers see no ticks
  assign half_tick = prescaler_tick & ~prescaler_reset;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      output_prescaler_reset <= 1'b0;
      sync_active <= 1'b0;
    end else begin
      output_prescaler_reset <= prescaler_reset;
      sync_active <= (state == OCSD_PULSE);
    end
  end

  // Channel A divider
  ocsd_chan_div u_chan_a (
    .core_clk(core_clk),
    .reset(reset),
    .half_tick(half_tick),
    .sync_pulse(state == OCSD_PULSE),
    .cfg(cfg_a),
    .clk_out(channel_a_output),
    .drive(channel_a_drive),
    .oe_n(channel_a_oe_n),
    .in_static(static_a)
  );

  // Channel B divider
  ocsd_chan_div u_chan_b (
    .core_clk(core_clk),
    .reset(reset),
    .half_tick(half_tick),
    .sync_pulse(state == OCSD_PULSE),
    .cfg(cfg_b),
    .clk_out(channel_b_output),
    .drive(channel_b_drive),
    .oe_n(channel_b_oe_n),
    .in_static(static_b)
  );

  chk_auto_off_quiet: assert property (@(posedge core_clk) disable iff (reset)
    (auto_mode == OCSD_AUTO_OFF || auto_mode == OCSD_AUTO_RSVD) |-> !trigger)
    else $error("sync triggered with automatic sync off");

  chk_analog_gate: assert property (@(posedge core_clk) disable iff (reset)
    (!analog_lock_sync_override && !(analog_loop_calibrated && analog_loop_locked)) |=> !armed)
    else $error("sync armed before analog loop lock");

  chk_override_arms: assert property (@(posedge core_clk) disable iff (reset)
    analog_lock_sync_override |=> armed)
    else $error("override did not arm sync");

  chk_direct_sync: assert property (@(posedge core_clk) disable iff (reset)
    (state == OCSD_IDLE && trigger && !sync_source_ref) |=> state == OCSD_PULSE ##1 sync_active)
    else $error("direct sync not issued next cycle");

  chk_ref_wait: assert property (@(posedge core_clk) disable iff (reset)
    (state == OCSD_WAIT_REF && !active_ref_edge) |=> state != OCSD_PULSE)
    else $error("reference sync fired without edge");

  chk_prescaler_hold: assert property (@(posedge core_clk) disable iff (reset)
    (prescaler_reset && $past(prescaler_reset) && !static_a && $stable(cfg_a)) |=> $stable(channel_a_output))
    else $error("channel A moved while prescaler held");

  chk_mask_b_release: assert property (@(posedge core_clk) disable iff (reset)
    channel_b_sync_mask |=> !static_b)
    else $error("masked channel B still static");

  chk_write_stores: assert property (@(posedge core_clk) disable iff (reset)
    (wr_go && idx == `OCSD_IDX_CHA_DIV_HIGH) |=> cfg_a.div[9:8] == $past(writedata[1:0]))
    else $error("divider high bits not stored");
endmodule : ocsd_top
`default_nettype wire

//--- ocsd_top_tb.sv
/*
  Self-checking bench for ocsd_top: register access, drive modes, divider
  ratio and phase, sync trigger, gating and channel masks.
  Assumes ocsd_pkg and the design files are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ocsd_defs.svh"
module ocsd_top_tb;
  import ocsd_pkg::*;
  logic core_clk, reset, read, write, waitrequest, tick, pre_rst, sync_act;
  logic f_lock, p_lock, cal, a_lock, ref_edge, a_out, a_oen, b_out, b_oen;
  logic [1:0] a_drv, b_drv;
  logic [13:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [11:0] idx_tab [6];
  logic [7:0] msk_tab [6];
  logic [9:0] div_tab [3];
  int err_count, check_count, t0, t1;

  ocsd_top ocsd_top_inst (
    .core_clk(core_clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .digital_loop_freq_lock(f_lock),
    .digital_loop_phase_lock(p_lock), .analog_loop_calibrated(cal),
    .analog_loop_locked(a_lock), .active_ref_edge(ref_edge),
    .prescaler_tick(tick), .output_prescaler_reset(pre_rst),
    .channel_a_output(a_out), .channel_a_drive(a_drv), .channel_a_oe_n(a_oen),
    .channel_b_output(b_out), .channel_b_drive(b_drv), .channel_b_oe_n(b_oen),
    .sync_active(sync_act)
  );

  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Half-tick every second cycle, so one tick equals two clock cycles
  always @(posedge core_clk) tick <= ~tick;

  task automatic print_verdict;
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One Avalon transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] d);
    int n;
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    read <= ~wr;
    write <= wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      err_count++;
      print_verdict();
    end
    @(posedge core_clk);
  endtask : bus

  // Looks for a sync indication over a fixed window
  task automatic await_sync(input logic exp);
    logic hit;
    hit = 1'b0;
    repeat (20) begin
      @(posedge core_clk);
      if (sync_act === 1'b1) hit = 1'b1;
    end
    check("sync_active", hit, exp);
  endtask : await_sync

  // Checks n output half periods; the first two may still run the old count
  task automatic gaps(input logic b, input int n, input int exp);
    int k, c;
    logic last;
    last = b ? b_out : a_out;
    k = -2;
    c = 0;
    while (k < n && c < 3000) begin
      @(posedge core_clk);
      c++;
      if ((b ? b_out : a_out) !== last) begin
        last = b ? b_out : a_out;
        if (k >= 0) check("half period", c, exp);
        k++;
        c = 0;
      end
    end
    check("half period count", k, n);
  endtask : gaps

  // Cycles from lock rise to the first rise after sync, from a fixed tick phase
  task automatic sync_time(output int t);
    f_lock <= 1'b0;
    repeat (6) @(posedge core_clk);
    if (tick !== 1'b1) @(posedge core_clk);
    f_lock <= 1'b1;
    t = 0;
    while (sync_act !== 1'b1 && t < 50) begin
      @(posedge core_clk);
      t++;
    end
    // Hold reaches the registered output two edges after the pulse shows
    repeat (2) begin
      @(posedge core_clk);
      t++;
    end
    check("static on sync", a_out, 1'b0);
    while (a_out !== 1'b1 && t < 400) begin
      @(posedge core_clk);
      t++;
    end
  endtask : sync_time

  // Hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end

  initial begin
    {reset, tick} = 2'b10;
    {read, write, f_lock, p_lock, cal, a_lock, ref_edge} = '0;
    address = '0;
    writedata = '0;
    idx_tab = '{`OCSD_IDX_SYNC_SETTINGS, `OCSD_IDX_SYNC_MASK, `OCSD_IDX_CHA_MODE,
                `OCSD_IDX_CHA_DIV_LOW, `OCSD_IDX_CHA_DIV_HIGH, `OCSD_IDX_CHA_PHASE};
    msk_tab = '{8'h07, 8'h07, 8'h07, 8'hFF, 8'h03, 8'h3F};
    div_tab = '{10'h000, 10'h002, 10'h105};
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check("drive", a_drv, 2'h0);
    check("oe_n", a_oen, 1'b0);
    check("b drive", b_drv, 2'h0);
    check("b oe_n", b_oen, 1'b0);
    // Reset values, then writable bits; reserved bits read back zero
    foreach (idx_tab[i]) begin
      bus(1'b0, idx_tab[i], 8'h00);
      check("reset value", rd, 32'h0);
      bus(1'b1, idx_tab[i], 8'hFF);
      bus(1'b0, idx_tab[i], 8'h00);
      check("readback", rd, {24'h0, msk_tab[i]});
      bus(1'b1, idx_tab[i], 8'h00);
    end
    bus(1'b1, 12'h440, 8'hFF);
    bus(1'b0, 12'h440, 8'h00);
    check("unmapped", rd, 32'h0);
    // Both dividers still static, nothing armed
    bus(1'b0, `OCSD_IDX_STATUS, 8'h00);
    check("status", rd, 32'h0000000C);
    // Output copy of the reset bit lags the register by one edge
    bus(1'b1, `OCSD_IDX_PRESCALER_CTRL, 8'h02);
    @(posedge core_clk);
    check("prescaler reset", pre_rst, 1'b1);
    bus(1'b1, `OCSD_IDX_PRESCALER_CTRL, 8'h00);
    @(posedge core_clk);
    check("prescaler run", pre_rst, 1'b0);
    // Static output level follows polarity
    bus(1'b1, `OCSD_IDX_CHA_MODE, 8'h01);
    repeat (3) @(posedge core_clk);
    check("inverted", a_out, 1'b1);
    bus(1'b1, `OCSD_IDX_CHA_MODE, 8'h00);
    repeat (3) @(posedge core_clk);
    check("normal", a_out, 1'b0);
    // Mask releases the divider but must not switch drivers on
    bus(1'b1, `OCSD_IDX_SYNC_MASK, 8'h01);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, `OCSD_IDX_CHA_MODE, {5'h0, m[1:0], 1'b0});
      repeat (3) @(posedge core_clk);
      check("drive", a_drv, m[1:0]);
      check("oe_n", a_oen, logic'(m == 3));
    end
    check("powered down", a_out, 1'b0);
    bus(1'b1, `OCSD_IDX_CHA_MODE, 8'h00);
    foreach (div_tab[i]) begin
      bus(1'b1, `OCSD_IDX_CHA_DIV_LOW, div_tab[i][7:0]);
      bus(1'b1, `OCSD_IDX_CHA_DIV_HIGH, {6'h0, div_tab[i][9:8]});
      gaps(1'b0, 3, 2 * (int'(div_tab[i]) + 1));
    end
    bus(1'b1, `OCSD_IDX_CHA_DIV_LOW, 8'h03);
    bus(1'b1, `OCSD_IDX_CHA_DIV_HIGH, 8'h00);
    bus(1'b1, `OCSD_IDX_SYNC_SETTINGS, 8'h01);
    bus(1'b1, `OCSD_IDX_SYNC_MASK, 8'h07);
    // A sync in mid-run must leave both masked channels undisturbed
    fork
      gaps(1'b0, 6, 8);
      gaps(1'b1, 6, 2);
      begin
        repeat (12) @(posedge core_clk);
        f_lock <= 1'b1;
      end
    join
    f_lock <= 1'b0;
    check("b drive", b_drv, 2'h0);
    check("b oe_n", b_oen, 1'b0);
    // Held prescaler freezes a running channel for longer than a half period
    bus(1'b1, `OCSD_IDX_PRESCALER_CTRL, 8'h02);
    @(posedge core_clk);
    rd[0] = a_out;
    repeat (20) @(posedge core_clk);
    check("held output", a_out, rd[0]);
    bus(1'b1, `OCSD_IDX_PRESCALER_CTRL, 8'h00);
    bus(1'b1, `OCSD_IDX_SYNC_MASK, 8'h04);
    // Every trigger code against each lock kind, analog loop ignored
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 2; k++) begin
        bus(1'b1, `OCSD_IDX_SYNC_SETTINGS, 8'(c));
        if (k == 1) p_lock <= 1'b1;
        else f_lock <= 1'b1;
        await_sync(logic'((c == 1 && k == 0) || (c == 2 && k == 1)));
        f_lock <= 1'b0;
        p_lock <= 1'b0;
        repeat (3) @(posedge core_clk);
      end
    end
    bus(1'b1, `OCSD_IDX_SYNC_MASK, 8'h00);
    bus(1'b1, `OCSD_IDX_SYNC_SETTINGS, 8'h01);
    f_lock <= 1'b1;
    await_sync(1'b0);
    cal <= 1'b1;
    a_lock <= 1'b1;
    await_sync(1'b1);
    f_lock <= 1'b0;
    bus(1'b1, `OCSD_IDX_SYNC_SETTINGS, 8'h05);
    f_lock <= 1'b1;
    await_sync(1'b0);
    ref_edge <= 1'b1;
    @(posedge core_clk);
    ref_edge <= 1'b0;
    await_sync(1'b1);
    bus(1'b1, `OCSD_IDX_SYNC_SETTINGS, 8'h01);
    // Phase offset: four half ticks more must delay the first rise by 8 cycles
    bus(1'b1, `OCSD_IDX_CHA_DIV_LOW, 8'h01);
    sync_time(t0);
    bus(1'b1, `OCSD_IDX_CHA_PHASE, 8'h04);
    sync_time(t1);
    check("phase offset", t1 - t0, 32'h8);
    print_verdict();
  end
endmodule : ocsd_top_tb
`default_nettype wire
